// File: hdl/asp_map.svh
// What this block does
// - control bit 7 picks 8- or 9-bit frames
// - 8-bit frame: start, eight data LSB first, stop
// - 8-bit accept: data to buffer, stop to bit 2
// - data buffer write starts a new character
// - transmit done set at stop-bit start
// - receiver starts a frame only when enable bit 4 set
// - 8-bit accept needs done clear, filtered stop high
// - overrun keeps first byte, drops later bits
// - rejected frame changes neither buffer nor flags
// - interrupt request when either done flag set
// - 9-bit frame: start, eight data, ninth, stop
// - 9-bit transmit sends control bit 3 ninth
// - 9-bit accept: ninth to bit 2, stop ignored
// - 9-bit accept needs done clear, filtered ninth high
// - filter bit 5 gates flagging per mode
// - only software clears the done flags
// - bit rate is timer overflow rate halved
// - start edge reloads the receive bit timer
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_CTRL_OFS 4'h0
`define ASP_DATA_OFS 4'h4
`define ASP_ADDR_W 4
`define ASP_BIT_MODE 7
`define ASP_BIT_FILT 5
`define ASP_BIT_REN 4
`define ASP_BIT_TB8 3
`define ASP_BIT_RB8 2
`define ASP_BIT_TXD 1
`define ASP_BIT_RXD 0
`define ASP_CTRL_RST 8'h00
`define ASP_DATA_RST 8'h00
`define ASP_LAST_8 4'h9
`define ASP_LAST_9 4'ha
`define ASP_RESP_OK 2'h0
`define ASP_RESP_ERR 2'h2
`endif

// File: hdl/asp_pkg.sv
`default_nettype none
package asp_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_DATA, TX_NINTH, TX_STOP, TX_END}
    asp_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asp_rx_state_type;
endpackage
`default_nettype wire

// File: hdl/asp_uart.sv
`include "asp_map.svh"
`default_nettype none
module asp_uart import asp_pkg::*; #(
  parameter int DATA_W = 32
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [`ASP_ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic [DATA_W/8-1:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [`ASP_ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [DATA_W-1:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic TIMER_OVF,
  input wire logic SERIAL_RX_LINE,
  output logic SERIAL_TX_LINE,
  output logic UART_IRQ
);

  if (DATA_W != 32) begin : g_chk
    $error("asp_uart serves a 32-bit data bus only");
  end

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [3:0] last_idx(input logic mode9);
    return mode9 ? `ASP_LAST_9 : `ASP_LAST_8;
  endfunction

  function automatic logic mapped(input logic [`ASP_ADDR_W-1:0] a);
    return (a == `ASP_CTRL_OFS) || (a == `ASP_DATA_OFS);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic mode_r, filt_r, ren_r, tb8_r, rb8_r, tx_done_r, rx_done_r;
  logic [7:0] rx_buf_r;
  logic aw_ready_r, w_ready_r, b_valid_r, ar_ready_r, r_valid_r;
  logic [`ASP_ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane_r;
  logic [DATA_W-1:0] r_data_r;
  logic [1:0] b_resp_r, r_resp_r;
  logic tx_line_r, irq_r;
  asp_tx_state_type tx_st_r;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_cnt_r;
  logic tx_tog_r;
  asp_rx_state_type rx_st_r;
  logic rx_q_r, rx_tog_r;
  logic [9:0] rx_sh_r;
  logic [3:0] rx_cnt_r;

  // ----------------------------------------
  // register bus slave
  // ----------------------------------------
  logic wr_go, wr_ctrl, wr_data;
  assign wr_go = !aw_ready_r && !w_ready_r && !b_valid_r;
  assign wr_ctrl = wr_go && w_lane_r && (aw_addr_r == `ASP_CTRL_OFS);
  assign wr_data = wr_go && w_lane_r && (aw_addr_r == `ASP_DATA_OFS);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      aw_ready_r <= 1'b1;
      w_ready_r <= 1'b1;
      b_valid_r <= 1'b0;
      b_resp_r <= `ASP_RESP_OK;
      aw_addr_r <= '0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
    end else begin
      if (AWVALID && aw_ready_r) begin
        aw_ready_r <= 1'b0;
        aw_addr_r <= AWADDR;
      end
      if (WVALID && w_ready_r) begin
        w_ready_r <= 1'b0;
        w_data_r <= WDATA[7:0];
        w_lane_r <= WSTRB[0];
      end
      if (wr_go) begin
        b_valid_r <= 1'b1;
        b_resp_r <= mapped(aw_addr_r) ? `ASP_RESP_OK : `ASP_RESP_ERR;
      end
      if (b_valid_r && BREADY) begin
        b_valid_r <= 1'b0;
        aw_ready_r <= 1'b1;
        w_ready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ar_ready_r <= 1'b1;
      r_valid_r <= 1'b0;
      r_data_r <= '0;
      r_resp_r <= `ASP_RESP_OK;
    end else if (ARVALID && ar_ready_r) begin
      ar_ready_r <= 1'b0;
      r_valid_r <= 1'b1;
      r_resp_r <= mapped(ARADDR) ? `ASP_RESP_OK : `ASP_RESP_ERR;
      r_data_r <= '0;
      if (ARADDR == `ASP_CTRL_OFS) begin
        r_data_r[7:0] <= {mode_r, 1'b0, filt_r, ren_r, tb8_r, rb8_r, tx_done_r, rx_done_r};
      end else if (ARADDR == `ASP_DATA_OFS) begin
        r_data_r[7:0] <= rx_buf_r;
      end
    end else if (r_valid_r && RREADY) begin
      r_valid_r <= 1'b0;
      ar_ready_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // control bits
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      {mode_r, filt_r, ren_r, tb8_r} <= 4'h0;
    end else if (wr_ctrl) begin
      mode_r <= w_data_r[`ASP_BIT_MODE];
      filt_r <= w_data_r[`ASP_BIT_FILT];
      ren_r <= w_data_r[`ASP_BIT_REN];
      tb8_r <= w_data_r[`ASP_BIT_TB8];
    end
  end

  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  logic tx_bit, rx_samp, rx_start;
  assign tx_bit = TIMER_OVF && tx_tog_r;
  // first overflow after the reload lands mid start bit
  assign rx_samp = TIMER_OVF && !rx_tog_r;
  assign rx_start = (rx_st_r == RX_IDLE) && ren_r && rx_q_r && !SERIAL_RX_LINE;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_tog_r <= 1'b0;
    end else if (TIMER_OVF) begin
      tx_tog_r <= !tx_tog_r;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rx_tog_r <= 1'b0;
      rx_q_r <= 1'b1;
    end else begin
      rx_q_r <= SERIAL_RX_LINE;
      if (rx_start) begin
        rx_tog_r <= 1'b0;
      end else if (TIMER_OVF) begin
        rx_tog_r <= !rx_tog_r;
      end
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= `ASP_DATA_RST;
      tx_cnt_r <= 3'h0;
      tx_line_r <= 1'b1;
    end else if (wr_data) begin
      // a write mid-frame restarts; the old character is cut short
      tx_st_r <= TX_LOAD;
      tx_sh_r <= w_data_r;
      tx_line_r <= 1'b1;
    end else if (tx_bit) begin
      unique case (tx_st_r)
        TX_IDLE: tx_line_r <= 1'b1;
        TX_LOAD: begin
          tx_line_r <= 1'b0;
          tx_cnt_r <= 3'h0;
          tx_st_r <= TX_DATA;
        end
        TX_DATA: begin
          tx_line_r <= tx_sh_r[0];
          tx_sh_r <= {1'b0, tx_sh_r[7:1]};
          tx_cnt_r <= tx_cnt_r + 3'h1;
          if (tx_cnt_r == 3'h7) begin
            tx_st_r <= mode_r ? TX_NINTH : TX_STOP;
          end
        end
        TX_NINTH: begin
          tx_line_r <= tb8_r;
          tx_st_r <= TX_STOP;
        end
        TX_STOP: begin
          tx_line_r <= 1'b1;
          tx_st_r <= TX_END;
        end
        TX_END: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic rx_fin, rx_ok, nin_bit;
  logic [7:0] rx_byte;
  assign rx_fin = (rx_st_r == RX_BITS) && rx_samp && (rx_cnt_r == last_idx(mode_r));
  assign rx_byte = mode_r ? rx_sh_r[8:1] : rx_sh_r[9:2];
  // in 8-bit frames the stop bit takes the ninth slot
  assign nin_bit = mode_r ? rx_sh_r[9] : SERIAL_RX_LINE;
  assign rx_ok = !rx_done_r && (!filt_r || nin_bit);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rx_st_r <= RX_IDLE;
      rx_sh_r <= 10'h000;
      rx_cnt_r <= 4'h0;
    end else begin
      unique case (rx_st_r)
        RX_IDLE: if (rx_start) rx_st_r <= RX_START;
        RX_START: if (rx_samp) begin
          // a glitch shorter than half a bit is dropped
          rx_st_r <= SERIAL_RX_LINE ? RX_IDLE : RX_BITS;
          rx_cnt_r <= 4'h1;
        end
        RX_BITS: if (rx_samp) begin
          rx_sh_r <= {SERIAL_RX_LINE, rx_sh_r[9:1]};
          rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_fin) rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // receive buffer and flags
  // ----------------------------------------
  logic tx_set, rx_set;
  assign tx_set = tx_bit && (tx_st_r == TX_STOP) && !wr_data;
  assign rx_set = rx_fin && rx_ok;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rx_buf_r <= `ASP_DATA_RST;
      rb8_r <= 1'b0;
    end else if (rx_set) begin
      rx_buf_r <= rx_byte;
      rb8_r <= nin_bit;
    end else if (wr_ctrl) begin
      rb8_r <= w_data_r[`ASP_BIT_RB8];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_done_r <= 1'b0;
      rx_done_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      // hardware set wins over a same-cycle software clear
      tx_done_r <= tx_set || (wr_ctrl ? w_data_r[`ASP_BIT_TXD] : tx_done_r);
      rx_done_r <= rx_set || (wr_ctrl ? w_data_r[`ASP_BIT_RXD] : rx_done_r);
      irq_r <= tx_done_r || rx_done_r;
    end
  end

  assign AWREADY = aw_ready_r;
  assign WREADY = w_ready_r;
  assign BVALID = b_valid_r;
  assign BRESP = b_resp_r;
  assign ARREADY = ar_ready_r;
  assign RVALID = r_valid_r;
  assign RDATA = r_data_r;
  assign RRESP = r_resp_r;
  assign SERIAL_TX_LINE = tx_line_r;
  assign UART_IRQ = irq_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // helper: overflows seen since the last transmit tick
  logic [1:0] ovf_gap_r;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ovf_gap_r <= 2'h0;
    end else if (tx_bit) begin
      ovf_gap_r <= 2'h0;
    end else if (TIMER_OVF) begin
      ovf_gap_r <= ovf_gap_r + 2'h1;
    end
  end

  sequence tx_frame_start;
    tx_st_r == TX_LOAD && tx_bit && !wr_data;
  endsequence

  sequence tx_ninth_slot;
    tx_st_r == TX_NINTH && tx_bit && !wr_data;
  endsequence

  tx_start_low_a: assert property (tx_frame_start |=> !tx_line_r && tx_st_r == TX_DATA)
    else $error("start bit not driven low");
  tx_ninth_a: assert property (tx_ninth_slot |=> tx_line_r == $past(tb8_r))
    else $error("ninth bit differs from control bit");
  tx_done_stop_a: assert property ($rose(tx_done_r) && $past(tx_st_r) == TX_STOP
      |-> tx_line_r && tx_st_r == TX_END)
    else $error("transmit done not at stop start");
  rate_half_a: assert property (tx_bit |-> ovf_gap_r == 2'h1)
    else $error("bit tick faster than half overflow rate");
  ren_gate_a: assert property (!ren_r && rx_st_r == RX_IDLE |=> rx_st_r == RX_IDLE)
    else $error("receiver started while disabled");
  rx_overrun_a: assert property (rx_done_r && !wr_ctrl |=> $stable(rx_buf_r) && rx_done_r)
    else $error("buffer changed while flag pending");
  rx_filter_a: assert property (rx_fin && filt_r && !nin_bit && !rx_done_r && !wr_ctrl
      |=> !rx_done_r && $stable(rx_buf_r))
    else $error("filtered frame accepted");
  flag_keep_a: assert property (tx_done_r && !wr_ctrl |=> tx_done_r [*1])
    else $error("transmit done cleared by hardware");
  irq_flags_a: assert property ((tx_done_r || rx_done_r) |=> UART_IRQ)
    else $error("interrupt missing for set flag");
  rx_accept_a: assert property (rx_fin && !rx_done_r && (!filt_r || nin_bit)
      |=> rx_done_r)
    else $error("qualified frame not flagged");
  rx_reload_a: assert property (rx_start |=> rx_st_r == RX_START && !rx_tog_r)
    else $error("receive timer not reloaded at start");
  tx_stop_high_a: assert property (tx_st_r == TX_END |-> tx_line_r)
    else $error("stop bit not held high");
  rx_ninth_a: assert property (rx_set && mode_r |=> rb8_r == $past(rx_sh_r[9]))
    else $error("ninth bit not stored");

endmodule
`default_nettype wire

// File: tb/asp_remote.sv
`default_nettype none
module asp_remote (
  input wire logic clk,
  input wire logic ovf,
  input wire logic tx_line,
  input wire logic irq,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ns;

  initial rx_line = 1'b1;

  task automatic tick(input int n);
    repeat (n) @(posedge clk iff ovf);
  endtask

  // ----------------------------------------
  // frame out: start, data lsb first, [ninth], stop
  // ----------------------------------------
  // bits change on overflow edges, so the device samples one overflow later
  task automatic send(input logic [10:0] f, input int n);
    tick(1);
    for (int i = 0; i < n; i++) begin
      rx_line <= f[i];
      tick(2);
    end
    rx_line <= 1'b1;
  endtask

  // mid-bit capture, irq snapshot beside each bit
  task automatic grab(input int n, output logic [10:0] v, output logic [10:0] q);
    v = '0;
    q = '0;
    @(posedge clk iff tx_line === 1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == 0 ? 1 : 2);
      v[i] = tx_line;
      q[i] = irq;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/test_async_serial_port_8_9bit.sv
`default_nettype none
module test_async_serial_port_8_9bit;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, TIMER_OVF;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SERIAL_RX_LINE, SERIAL_TX_LINE, UART_IRQ;
  logic [3:0] AWADDR, ARADDR, WSTRB;
  logic [31:0] WDATA, RDATA, rd_v;
  logic [1:0] BRESP, RRESP, resp;
  logic [10:0] fv, fq;
  logic [7:0] ebuf, d, c;
  logic erb8, erxd, m, f, en, nin, stp;
  int err_total = 0;
  int compares = 0;
  int ovf_cnt = 0;

  asp_uart u_asp_uart (.CLOCK(CLOCK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .TIMER_OVF(TIMER_OVF), .SERIAL_RX_LINE(SERIAL_RX_LINE),
    .SERIAL_TX_LINE(SERIAL_TX_LINE), .UART_IRQ(UART_IRQ));
  asp_remote u_asp_remote (.clk(CLOCK), .ovf(TIMER_OVF), .tx_line(SERIAL_TX_LINE),
    .irq(UART_IRQ), .rx_line(SERIAL_RX_LINE));

  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  // overflow every 4 clocks: one bit time is 8 clocks
  always @(posedge CLOCK) begin
    ovf_cnt <= (ovf_cnt + 1) % 4;
    TIMER_OVF <= (ovf_cnt == 3);
  end

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] dv, input logic [3:0] s);
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= {24'h0, dv};
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    resp = BRESP;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    RREADY <= 1'b0;
    rd_v = RDATA;
    resp = RRESP;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [10:0] txf(logic [7:0] dv, logic m9, logic n9, logic s);
    return m9 ? {s, n9, dv, 1'b0} : {1'b0, s, dv, 1'b0};
  endfunction

  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge CLOCK);
    err_total++;
    wrap_up();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    RST = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WSTRB, WDATA} = '0;
    void'($urandom(32'h6c8467e4));
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    rd(4'h0);
    chk("ctrl reset", 32'h0, rd_v);
    chk("ctrl rresp", 32'h0, {30'h0, resp});
    rd(4'h8);
    chk("unmapped read", 32'h2, {30'h0, resp});
    chk("unmapped rdata", 32'h0, rd_v);
    wr(4'h8, 8'hff, 4'hf);
    chk("unmapped write", 32'h2, {30'h0, resp});
    wr(4'h0, 8'hff, 4'h0);
    chk("strobe off bresp", 32'h0, {30'h0, resp});
    rd(4'h0);
    chk("strobe off write", 32'h0, rd_v);
    wr(4'h0, 8'h48, 4'hf);
    rd(4'h0);
    chk("ctrl unused bit", 32'h8, rd_v);
    // transmit: 8-bit, then 9-bit with ninth bit 0 and 1
    for (int k = 0; k < 3; k++) begin
      m = (k != 0);
      nin = (k == 2);
      d = 8'($urandom);
      wr(4'h0, {m, 3'h0, nin, 3'h0}, 4'hf);
      fork
        wr(4'h4, d, 4'hf);
        u_asp_remote.grab(10 + m, fv, fq);
      join
      chk("tx frame", {21'h0, txf(d, m, nin, 1'b1)}, {21'h0, fv});
      chk("irq at stop", 32'h1 << (9 + m), {21'h0, fq});
      repeat (40) @(posedge CLOCK);
      rd(4'h0);
      chk("tx done kept", {24'h0, m, 3'h0, nin, 3'h2}, rd_v);
    end
    // receive: random mode, filter, enable, ninth, stop; flag kept for overruns
    {ebuf, erb8, erxd} = '0;
    for (int k = 0; k < 24; k++) begin
      c = 8'($urandom);
      d = 8'($urandom);
      {m, f, nin} = {c[7], c[5], c[2]};
      en = c[4] | c[3];
      stp = c[1] | c[6];
      erxd = erxd & c[0];
      wr(4'h0, {m, 1'b0, f, en, 1'b0, erb8, 1'b0, erxd}, 4'hf);
      u_asp_remote.send(txf(d, m, nin, stp), 10 + m);
      if (en && !erxd && (!f || (m ? nin : stp))) begin
        ebuf = d;
        erb8 = m ? nin : stp;
        erxd = 1'b1;
      end
      repeat (4) @(posedge CLOCK);
      rd(4'h4);
      chk("rx buffer", {24'h0, ebuf}, rd_v);
      rd(4'h0);
      chk("rx ctrl", {24'h0, m, 1'b0, f, en, 1'b0, erb8, 1'b0, erxd}, rd_v);
      chk("irq level", {31'h0, erxd}, {31'h0, UART_IRQ});
    end
    // mid-run reset returns every control bit to zero
    @(posedge CLOCK);
    RST <= 1'b1;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    rd(4'h0);
    chk("ctrl after reset", 32'h0, rd_v);
    chk("irq after reset", 32'h0, {31'h0, UART_IRQ});
    chk("tx idle after reset", 32'h1, {31'h0, SERIAL_TX_LINE});
    wrap_up();
  end
endmodule
`default_nettype wire
